// File: pkg/sadc_pkg.sv
// constants shared by the converter control core, its pin synchroniser and its result fifo
// assumes a single 100 MHz clock (mclk) and a synchronous active-high reset (rst)
package sadc_pkg;

  // result and bus widths
  localparam int unsigned RES_W     = 14;            // normal result bits
  localparam int unsigned OUT_W     = 15;            // result bits plus overrange bit
  localparam int unsigned OVR_BIT   = 14;            // position of overrange_data_bit
  localparam int unsigned RAW_W     = 16;            // signed code from the sar datapath
  localparam int unsigned SUM_W     = 17;            // raw plus offset, one guard bit

  // clamp values for saturation, reset values of the offset and output registers
  localparam logic [RES_W-1:0] CODE_MAX   = 14'h3fff;
  localparam logic [RES_W-1:0] CODE_MIN   = 14'h0000;
  localparam logic [OUT_W-1:0] OFFSET_RST = 15'h0000;
  localparam logic [OUT_W-1:0] DOUT_RST   = 15'h0000;

  // conversion timing: longest time, so round down
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CONV_TIME_NS  = 300;
  localparam int unsigned CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 5;

  // result buffering
  localparam int unsigned FIFO_DEPTH = 8;

  // synchronised control pin positions
  localparam int unsigned PIN_CONV  = 0;
  localparam int unsigned PIN_RSTN  = 1;
  localparam int unsigned PIN_CSN   = 2;
  localparam int unsigned PIN_RDN   = 3;
  localparam int unsigned PIN_WR    = 4;
  localparam int unsigned PIN_SELLO = 5;
  localparam int unsigned PIN_SELHI = 6;
  localparam int unsigned PIN_SAT   = 7;
  localparam int unsigned PIN_W     = 8;
  // idle levels of the pins: active-low ones idle high
  localparam logic [PIN_W-1:0] PIN_IDLE = 8'h0f;

  // control state machine, gray along idle -> conv -> done
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_CONV = 2'b01,
    SADC_DONE = 2'b11
  } sadc_state_t;

  // operating mode from {op_select_high, op_select_low}
  typedef enum logic [1:0] {
    SADC_MODE_PAR1 = 2'b00,
    SADC_MODE_PAR2 = 2'b01,
    SADC_MODE_RSV2 = 2'b10,
    SADC_MODE_RSV3 = 2'b11
  } sadc_mode_t;

endpackage : sadc_pkg

// File: rtl/sadc_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes pins are unrelated to mclk; reset value gives each pin its idle level
module sadc_sync
  import sadc_pkg::*;
#(
  parameter int unsigned      W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // clock and control
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sadc_sync_t;

  sadc_sync_t q;
  sadc_sync_t d;

  // first stage feeds only the second stage
  always_comb begin
    d        = q;
    d.meta   = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '{meta: RST_VAL, stable: RST_VAL};
    end else if (ce) begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule : sadc_sync

// File: rtl/sadc_fifo.sv
// result fifo with registered read data and valid/ready on both sides
// assumes one clock; in_ready low means full, out_valid low means empty
module sadc_fifo
  import sadc_pkg::*;
#(
  parameter int unsigned W     = OUT_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and control
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
    logic [W-1:0]            rdata;
    logic                    rvalid;
  } sadc_fifo_t;

  sadc_fifo_t  q;
  sadc_fifo_t  d;
  logic [AW:0] used;
  logic [AW:0] level;
  logic        take;

  // fill level counts the word parked in the read register too,
  // otherwise the fifo would quietly hold one word more than DEPTH
  assign used     = q.wp - q.rp;
  assign level    = used + (AW+1)'(q.rvalid);
  assign in_ready = (level != (AW+1)'(DEPTH));

  // write into the store, refill the output register when it empties
  always_comb begin
    d    = q;
    take = 1'b0;
    if (in_valid && in_ready) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp                = q.wp + (AW+1)'(1);
    end
    if (q.rvalid && out_ready) begin
      d.rvalid = 1'b0;
    end
    if ((used != '0) && (!q.rvalid || out_ready)) begin
      take = 1'b1;
    end
    if (take) begin
      d.rdata  = q.mem[q.rp[AW-1:0]];
      d.rvalid = 1'b1;
      d.rp     = q.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign out_valid = q.rvalid;
  assign out_data  = q.rdata;

endmodule : sadc_fifo

// File: rtl/sadc_core.sv
// conversion control core of a 14-bit successive-approximation converter:
// convert-start, reset pin, offset word, saturation, overrange bit, busy,
// result fifo and the three-state parallel result bus
// assumes all host pins are asynchronous to mclk; sample_code comes from the
// sar datapath on mclk and is valid whenever a conversion is started
//
// Chosen here: the chip-select-and-strobe port and the placing of the registers.
module sadc_core
  import sadc_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  // conversion control pins
  input  wire logic             convert_start_n,
  input  wire logic             reset_n,
  input  wire logic             op_select_low,
  input  wire logic             op_select_high,
  input  wire logic             saturate_enable,
  // parallel bus strobes
  input  wire logic             cs_n,
  input  wire logic             rd_n,
  input  wire logic             write,
  // parallel data bus, bit 14 is overrange_data_bit
  input  wire logic [OUT_W-1:0] data_in,
  output logic      [OUT_W-1:0] data_out,
  output logic                  data_oe_n,
  // status pins
  output logic                  busy,
  output logic                  hold,
  // sar datapath code, two's complement, nominal range 0 .. 16383
  input  wire logic [RAW_W-1:0] sample_code
);

  // all state of the core
  typedef struct packed {
    sadc_state_t      state;
    logic [CNT_W-1:0] cnt;
    logic [RAW_W-1:0] sample;
    logic [OUT_W-1:0] offset;
    logic [OUT_W-1:0] pend;
    logic             pend_valid;
    logic [OUT_W-1:0] out_reg;
    logic             out_valid;
    logic             conv_prev;
    logic             rstn_prev;
    logic             wr_prev;
    logic             read_prev;
    logic             busy;
    logic             hold;
    logic [OUT_W-1:0] dout;
    logic             doe_n;
  } sadc_core_t;

  localparam sadc_core_t CORE_RST = '{
    state:      SADC_IDLE,
    cnt:        '0,
    sample:     '0,
    offset:     OFFSET_RST,
    pend:       '0,
    pend_valid: 1'b0,
    out_reg:    DOUT_RST,
    out_valid:  1'b0,
    conv_prev:  1'b1,
    rstn_prev:  1'b1,
    wr_prev:    1'b0,
    read_prev:  1'b0,
    busy:       1'b1,
    hold:       1'b0,
    dout:       DOUT_RST,
    doe_n:      1'b1
  };

  sadc_core_t q;
  sadc_core_t d;

  // synchronised pins
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic [OUT_W-1:0] din_s;

  // fifo handshakes
  logic             push;
  logic [OUT_W-1:0] push_data;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [OUT_W-1:0] fifo_out_data;
  logic             fifo_out_ready;

  // decoded pin events and result arithmetic
  logic              conv_fall;
  logic              rstn_fall;
  logic              wr_fall;
  logic              read_now;
  logic              read_rise;
  sadc_mode_t        mode;
  logic              mode_two;
  logic [SUM_W-1:0]  sum;
  logic              over;
  logic              under;
  logic [RES_W-1:0]  code;
  logic [OUT_W-1:0]  result;

  // gather the control pins for one synchroniser bank
  assign pins_raw[PIN_CONV]  = convert_start_n;
  assign pins_raw[PIN_RSTN]  = reset_n;
  assign pins_raw[PIN_CSN]   = cs_n;
  assign pins_raw[PIN_RDN]   = rd_n;
  assign pins_raw[PIN_WR]    = write;
  assign pins_raw[PIN_SELLO] = op_select_low;
  assign pins_raw[PIN_SELHI] = op_select_high;
  assign pins_raw[PIN_SAT]   = saturate_enable;

  sadc_sync #(
    .W       (PIN_W),
    .RST_VAL (PIN_IDLE)
  ) u_pin_sync (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  // data bus is only sampled on a write, still it crosses like any pin
  sadc_sync #(
    .W       (OUT_W),
    .RST_VAL ('0)
  ) u_data_sync (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .async_in (data_in),
    .sync_out (din_s)
  );

  // results wait here until the output register is free for them
  sadc_fifo #(
    .W     (OUT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_result_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // the output register takes a new word only once the last one was read
  assign fifo_out_ready = ~q.out_valid;

  // edges seen on synchronised levels only
  assign conv_fall = q.conv_prev & ~pins_s[PIN_CONV];
  assign rstn_fall = q.rstn_prev & ~pins_s[PIN_RSTN];
  assign wr_fall   = q.wr_prev & ~pins_s[PIN_WR] & ~pins_s[PIN_CSN];
  assign read_now  = ~pins_s[PIN_CSN] & ~pins_s[PIN_RDN];
  assign read_rise = q.read_prev & ~read_now;

  // mode decode; unused codes behave as the first parallel mode
  assign mode     = sadc_mode_t'({pins_s[PIN_SELHI], pins_s[PIN_SELLO]});
  assign mode_two = (mode == SADC_MODE_PAR2);

  // offset correction with one guard bit, both operands sign-extended
  assign sum   = {q.sample[RAW_W-1], q.sample}
               + {{(SUM_W-OUT_W){q.offset[OUT_W-1]}}, q.offset};
  assign under = sum[SUM_W-1];
  assign over  = ~sum[SUM_W-1] & (|sum[SUM_W-2:RES_W]);

  // clipping forces all ones or all zeros; without it the low bits wrap
  always_comb begin
    code = sum[RES_W-1:0];
    if (pins_s[PIN_SAT] && over) begin
      code = CODE_MAX;
    end else if (pins_s[PIN_SAT] && under) begin
      code = CODE_MIN;
    end
  end

  // overrange flag rides above the normal result bits
  assign result = {over | under, code};

  // next-state logic for the whole core
  always_comb begin
    d         = q;
    push      = 1'b0;
    push_data = q.pend;

    // edge detectors follow the synchronised pins
    d.conv_prev = pins_s[PIN_CONV];
    d.rstn_prev = pins_s[PIN_RSTN];
    d.wr_prev   = pins_s[PIN_WR];
    d.read_prev = read_now;

    // host capture of the offset word on the write fall
    if (wr_fall) begin
      d.offset = din_s;
    end

    // a finished read frees the output register for the next result
    if (q.out_valid && read_rise) begin
      d.out_valid = 1'b0;
    end
    if (fifo_out_valid && !q.out_valid) begin
      d.out_reg   = fifo_out_data;
      d.out_valid = 1'b1;
    end

    // bus drives the output register only while both strobes are low
    d.doe_n = ~read_now;
    d.dout  = q.out_reg;

    if (!pins_s[PIN_RSTN]) begin
      // reset pin low: abort, stay idle, refuse every start
      d.state      = SADC_IDLE;
      d.cnt        = '0;
      d.pend_valid = 1'b0;
      d.busy       = 1'b1;
      d.hold       = 1'b0;
      if (rstn_fall) begin
        d.offset = OFFSET_RST;
      end
    end else begin
      unique case (q.state)
        SADC_IDLE: begin
          // a start needs room for the word it may push
          if (conv_fall && fifo_in_ready) begin
            if (mode_two && q.pend_valid) begin
              push         = 1'b1;
              push_data    = q.pend;
              d.pend_valid = 1'b0;
            end
            d.sample = sample_code;
            d.hold   = 1'b1;
            d.busy   = 1'b0;
            d.cnt    = CNT_W'(CONV_CYC - 1);
            d.state  = SADC_CONV;
          end
        end
        SADC_CONV: begin
          if (q.cnt == '0) begin
            d.hold = 1'b0;
            if (mode_two) begin
              // second mode: result parked until the next start
              d.pend       = result;
              d.pend_valid = 1'b1;
              d.busy       = 1'b1;
              d.state      = SADC_IDLE;
            end else begin
              d.state = SADC_DONE;
            end
          end else begin
            d.cnt = q.cnt - CNT_W'(1);
          end
        end
        SADC_DONE: begin
          // first mode: busy rises only once the result is latched;
          // a full fifo stalls here rather than drop a result
          push      = 1'b1;
          push_data = result;
          if (fifo_in_ready) begin
            d.busy  = 1'b1;
            d.state = SADC_IDLE;
          end
        end
      endcase
    end
  end

  // single state register, frozen while ce is low
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= CORE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // every output straight from the state register
  assign data_out  = q.dout;
  assign data_oe_n = q.doe_n;
  assign busy      = q.busy;
  assign hold      = q.hold;

endmodule : sadc_core

// File: test/sadc_core_checker.sv
// port-level assertions for the conversion control core
// assumes host pins change after mclk edges and stay put through the 2-flop sync
module sadc_core_checker
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // host pins
  input wire logic convert_start_n,
  input wire logic reset_n,
  input wire logic op_select_low,
  input wire logic op_select_high,
  input wire logic cs_n,
  input wire logic rd_n,
  // status and bus enable
  input wire logic busy,
  input wire logic hold,
  input wire logic data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run_q; // cycles hold has stood high
  logic       m2;    // parallel mode 2 selected
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // hold length counter; 8 bits so an overlong hold cannot wrap back to 30
  always_ff @(posedge mclk) begin
    run_q <= hold ? run_q + 8'h01 : 8'h00;
  end
  assign m2 = op_select_low & ~op_select_high;
  chk_start_busy: assert property ($rose(hold) |-> $fell(busy))
    else $error("hold rose without busy falling");
  chk_start_pin: assert property ($rose(hold) |-> !$past(convert_start_n, 2))
    else $error("conversion began without a start edge");
  chk_no_start: assert property ($rose(hold) |-> $past(reset_n, 3))
    else $error("conversion began while reset pin low");
  chk_conv_time: assert property (
    $fell(hold) && reset_n && $past(reset_n, 3) |-> run_q == 8'd30)
    else $error("conversion length not 30 cycles");
  chk_hold_bound: assert property (run_q <= 8'd30)
    else $error("hold stood beyond the conversion time");
  chk_busy_op_select_low: assert property (
    $fell(hold) && !m2 && reset_n && $past(reset_n, 3) |-> !busy ##1 busy)
    else $error("mode 1 busy did not rise after the latch");
  chk_busy_op_select_high: assert property (
    $fell(hold) && m2 && reset_n && $past(reset_n, 3) |-> $rose(busy))
    else $error("mode 2 busy did not rise at conversion end");
  chk_reset_pin: assert property ($fell(reset_n) |-> ##3 (busy && !hold)[*3])
    else $error("reset pin did not return to idle");
  chk_bus_drive: assert property ((!cs_n && !rd_n)[*4] |-> !data_oe_n)
    else $error("bus not driven during read");
  chk_bus_free: assert property ((cs_n || rd_n)[*4] |-> data_oe_n)
    else $error("bus driven outside read");
  // main scenarios reached
  cov_op_select_low: cover property ($fell(hold) && !m2);
  cov_op_select_high: cover property ($fell(hold) && m2);
  cov_abort: cover property ($fell(hold) && !reset_n);
endmodule : sadc_core_checker

// File: test/sadc_host.sv
// host model on the converter's parallel pins
// assumes callers enter each task just after a rising mclk edge
module sadc_host
  import sadc_pkg::*;
(
  // clock
  input wire logic             mclk,
  // converter pins
  output logic                 convert_start_n,
  output logic                 reset_n,
  output logic                 cs_n,
  output logic                 rd_n,
  output logic                 write,
  output logic     [OUT_W-1:0] data_in,
  // returned bus
  input wire logic [OUT_W-1:0] data_out,
  input wire logic             data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels from time zero
  initial begin
    convert_start_n = 1'b1;
    reset_n = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    write = 1'b0;
    data_in = 15'h0000;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // start pulse, long enough to pass the synchroniser
  task automatic start();
    convert_start_n <= 1'b0;
    tick(5);
    convert_start_n <= 1'b1;
    tick(3);
  endtask : start
  // low reset pulse; a start tried while held low must be ignored
  task automatic pin_reset();
    reset_n <= 1'b0;
    tick(3);
    start();
    reset_n <= 1'b1;
    tick(4);
  endtask : pin_reset
  // offset write: data held around the falling write edge
  task automatic wr_offset(input logic [OUT_W-1:0] v);
    data_in <= v;
    cs_n <= 1'b0;
    write <= 1'b1;
    tick(4);
    write <= 1'b0;
    tick(4);
    cs_n <= 1'b1;
    data_in <= ~v; // released bus never shows the last word
    tick(1);
  endtask : wr_offset
  // read: strobes stand six cycles, past the edge that drives the bus; word taken at the last edge
  task automatic rd(output logic [OUT_W-1:0] d, output logic oe_n);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    tick(6);
    d = data_out;
    oe_n = data_oe_n;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    tick(8);
  endtask : rd
endmodule : sadc_host

// File: test/tb.sv
// self-checking bench for the conversion control core
// assumes the host model drives the pins; a queue model predicts every result
module tb
  import sadc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic             mclk, rst, ce, op_select_low, op_select_high, saturate_enable;
  logic             convert_start_n, reset_n, cs_n, rd_n, write, busy, hold, data_oe_n;
  logic [RAW_W-1:0] sample_code;
  logic [OUT_W-1:0] data_in, data_out, got, off_w, park;
  logic [OUT_W-1:0] exp_q[$];
  logic             oe_got, parked;
  logic [15:0]      lfsr_q;
  int               bad_count, tests_run, offv, n;

  sadc_core dut (.mclk, .rst, .ce, .convert_start_n, .reset_n, .op_select_low,
    .op_select_high, .saturate_enable, .cs_n, .rd_n, .write, .data_in, .data_out,
    .data_oe_n, .busy, .hold, .sample_code);
  sadc_host host (.mclk, .convert_start_n, .reset_n, .cs_n, .rd_n, .write, .data_in,
    .data_out, .data_oe_n);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // expected word: range flag above the clipped or wrapped code
  function automatic logic [OUT_W-1:0] expect_word(input int s, input bit sat);
    logic [13:0] c;
    c = s[13:0];
    if (sat && s > 16383) c = 14'h3fff;
    if (sat && s < 0) c = 14'h0000;
    return {s > 16383 || s < 0, c};
  endfunction : expect_word
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk_word(input logic [OUT_W-1:0] g, input logic [OUT_W-1:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_bit(input logic g, input logic e);
    chk_word({14'h0000, g}, {14'h0000, e});
  endtask : chk_bit
  // bounded wait for busy; running out ends the run
  task automatic wait_busy();
    n = 0;
    while (busy !== 1'b1 && n < 80) begin
      @(posedge mclk);
      n++;
    end
    if (busy !== 1'b1) begin
      bad_count++;
      conclude();
    end
  endtask : wait_busy
  // one accepted conversion with a random code; mode 2 parks its result
  task automatic conv();
    logic [OUT_W-1:0] w;
    lfsr_q = lfsr(lfsr_q);
    sample_code <= {1'b0, lfsr_q[14:0]} - 16'h1000;
    saturate_enable <= lfsr_q[15];
    @(posedge mclk);
    w = expect_word($signed(sample_code) + offv, saturate_enable);
    host.start();
    wait_busy();
    if (op_select_low && !op_select_high) begin
      if (parked) exp_q.push_back(park);
      park = w;
      parked = 1'b1;
    end else exp_q.push_back(w);
    repeat (8) @(posedge mclk);
  endtask : conv
  task automatic read_cmp();
    host.rd(got, oe_got);
    chk_bit(oe_got, 1'b0);
    chk_word(got, exp_q.pop_front());
  endtask : read_cmp
  // reset pin pulse: offset and parked result gone, no start taken
  task automatic pin_rst();
    host.pin_reset();
    offv = 0;
    parked = 1'b0;
    chk_bit(hold, 1'b0);
    chk_bit(busy, 1'b1);
  endtask : pin_rst
  task automatic set_off();
    lfsr_q = lfsr(lfsr_q);
    off_w = {{4{lfsr_q[10]}}, lfsr_q[10:0]};
    host.wr_offset(off_w);
    offv = $signed(off_w);
  endtask : set_off

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {op_select_high, op_select_low} = 2'b00;
    saturate_enable = 1'b0;
    sample_code = 16'h0000;
    lfsr_q = 16'h0045;
    bad_count = 0;
    tests_run = 0;
    offv = 0;
    parked = 1'b0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    // every mode code; first conversion after the pin reset runs with offset cleared
    for (int m = 0; m < 4; m++) begin
      pin_rst();
      {op_select_high, op_select_low} <= m[1:0];
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
        if (i == 1) set_off();
        conv();
        if (exp_q.size() > 0) read_cmp();
      end
    end
    // fill fifo and output register unread, then a start must be refused
    for (int i = 0; i < FIFO_DEPTH + 1; i++) conv();
    host.start();
    chk_bit(hold, 1'b0);
    chk_bit(busy, 1'b1);
    while (exp_q.size() > 0) read_cmp();
    // abort mid-conversion: result dropped, offset cleared
    set_off();
    host.start();
    repeat (6) @(posedge mclk);
    pin_rst();
    conv();
    read_cmp();
    conclude();
  end
endmodule : tb

bind sadc_core sadc_core_checker u_chk (.mclk, .rst, .convert_start_n, .reset_n,
  .op_select_low, .op_select_high, .cs_n, .rd_n, .busy, .hold, .data_oe_n);
